// ---- rtl/cswt_top.sv ----
// cyclic sense and cyclic wake timers with a wishbone register file
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`include "cswt_consts.svh"
`default_nettype none
module cswt_top #(
    parameter int NHS = 4,
    parameter int NWK = 3,
    parameter int TICK_CYC = `CSWT_TICK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cswt_pkg::cswt_wb_req_s wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire cswt_pkg::cswt_mode_e mode_i,
    input wire logic sleep_req_i,
    input wire logic [NWK-1:0] wake_in_i,
    input wire logic [NHS-1:0] hs_fault_i,
    output logic [NHS-1:0] high_side_switch_o,
    output logic [NWK-1:0] static_sense_o,
    output logic int_o,
    output logic wake_up_o,
    output logic restart_o
);
    import cswt_pkg::*;
    localparam int FILT_CYC = `CSWT_FILT_CYC;

    // period in ticks
    function automatic logic [14:0] per_ticks(input logic [2:0] c);
        logic [31:0] us;
        unique case (c)
            3'h0: us = `CSWT_PER0_US;
            3'h1: us = `CSWT_PER1_US;
            3'h2: us = `CSWT_PER2_US;
            3'h3: us = `CSWT_PER3_US;
            3'h4: us = `CSWT_PER4_US;
            3'h5: us = `CSWT_PER5_US;
            default: us = `CSWT_PER6_US;
        endcase
        return 15'(us / `CSWT_TICK_US);
    endfunction

    // on-time in ticks, zero for the static settings
    function automatic logic [7:0] on_ticks(input logic [2:0] c);
        logic [31:0] us;
        unique case (c)
            3'h1: us = `CSWT_ON1_US;
            3'h2: us = `CSWT_ON2_US;
            3'h3: us = `CSWT_ON3_US;
            3'h4: us = `CSWT_ON4_US;
            3'h5: us = `CSWT_ON5_US;
            default: us = 32'h0;
        endcase
        return 8'(us / `CSWT_TICK_US);
    endfunction

    logic fs, awake;
    logic acc, wr_en;
    logic [31:0] wdat;
    logic [7:0] adr;
    logic wr_mapa, wr_mapb, wr_wsrc, wr_sta, wr_stb, wr_ctl;
    logic [1:0] wr_t, run_v, on_v, first_v, start_p, end_p, bad_v;
    cswt_tset_s tset_v [2];
    logic [2*NHS-1:0] map_a_q;
    logic [2*NWK-1:0] map_b_q;
    logic [1:0] wsrc_q, cw_flag_q, cw_ev;
    logic [NWK-1:0] wk_flag_q, lvl_q, ev_v, smp_v, cap_v, stat_d;
    logic [NHS-1:0] fault_q, hs_d;
    logic cmd_fail_q;
    logic [11:0] tick_cnt_q;
    logic tick;
    logic [31:0] rd_d;

    // mode and bus decode
    assign fs = (mode_i == CSWT_FAILSAFE);
    assign awake = (mode_i == CSWT_NORMAL) || (mode_i == CSWT_STOP);
    assign acc = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
    assign wr_en = wb_req_i.cyc & wb_req_i.stb & wb_ack_o & wb_req_i.we &
                   wb_req_i.sel[0]; // write lands on the ack edge
    assign wdat = wb_req_i.dat;
    assign adr = wb_req_i.adr;
    assign wr_t[0] = wr_en && adr == `CSWT_A_TMR1;
    assign wr_t[1] = wr_en && adr == `CSWT_A_TMR2;
    assign wr_mapa = wr_en && adr == `CSWT_A_MAPA;
    assign wr_mapb = wr_en && adr == `CSWT_A_MAPB;
    assign wr_wsrc = wr_en && adr == `CSWT_A_WSRC;
    assign wr_sta = wr_en && adr == `CSWT_A_STA;
    assign wr_stb = wr_en && adr == `CSWT_A_STB;
    assign wr_ctl = wr_en && adr == `CSWT_A_CTL;

    // shared 0.1 ms tick for both timers
    always_ff @(posedge clk_i) begin
        if (rst_i || tick) begin
            tick_cnt_q <= 12'h000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 12'h001;
        end
    end
    assign tick = (tick_cnt_q == 12'(TICK_CYC - 1));

    // the two periodic timers
    for (genvar t = 0; t < 2; t++) begin : g_tmr
        cswt_tset_s set_q, nset;
        logic run_q, on_q, first_q;
        logic [14:0] cnt_q, per;
        logic [7:0] ont;
        assign nset.on = wdat[`CSWT_ON_LSB +: 3];
        assign nset.per = wdat[`CSWT_PER_LSB +: 3];
        assign per = per_ticks(set_q.per);
        assign ont = on_ticks(set_q.on);
        assign start_p[t] = run_q & tick & (cnt_q == 15'h0000);
        assign end_p[t] = run_q & tick & (cnt_q == 15'(ont));
        assign bad_v[t] = wr_t[t] &&
            15'(on_ticks(nset.on)) > per_ticks(nset.per);
        assign run_v[t] = run_q;
        assign on_v[t] = on_q;
        assign first_v[t] = first_q;
        assign tset_v[t] = set_q;
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                set_q <= '{on: `CSWT_RST_ON, per: `CSWT_RST_PER};
                run_q <= 1'b0;
                on_q <= 1'b0;
                first_q <= 1'b0;
                cnt_q <= 15'h0000;
            end else if (wr_t[t]) begin
                set_q <= nset;
                run_q <= on_ticks(nset.on) != 8'h00;
                on_q <= 1'b0;
                first_q <= 1'b1;
                cnt_q <= 15'h0000;
            end else if (fs) begin
                run_q <= 1'b0;
                on_q <= 1'b0;
            end else if (run_q && tick) begin
                cnt_q <= (cnt_q == per - 15'h0001) ? 15'h0000
                                                   : cnt_q + 15'h0001;
                if (start_p[t]) begin
                    on_q <= 1'b1;
                    first_q <= 1'b0;
                end else if (end_p[t]) begin
                    on_q <= 1'b0;
                end
            end
        end
    end

    // timer to switch mapping and switch drive
    for (genvar j = 0; j < NHS; j++) begin : g_hs
        logic [1:0] sel;
        logic lvl;
        assign sel = map_a_q[2*j +: 2];
        always_comb begin
            lvl = 1'b0;
            if (sel == 2'h1) begin
                lvl = run_v[0] ? on_v[0]
                    : (tset_v[0].on == `CSWT_ON_OFF_HIGH);
            end else if (sel == 2'h2) begin
                lvl = run_v[1] ? on_v[1]
                    : (tset_v[1].on == `CSWT_ON_OFF_HIGH);
            end
            hs_d[j] = lvl & ~fault_q[j] & ~fs;
        end
    end

    // latched switch faults, cleared by rewriting the mapping
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_q <= '0;
        end else begin
            fault_q <= (fault_q & ~{NHS{wr_mapa}}) |
                       (hs_fault_i & {NHS{~fs}});
        end
    end

    // wake input sampling and filtering
    for (genvar k = 0; k < NWK; k++) begin : g_wk
        cswt_filt_e st_q;
        logic [9:0] fcnt_q;
        logic cap_q, ref_q, refv_q, done_q, samp, clr;
        logic [1:0] wsel;
        assign wsel = map_b_q[2*k +: 2];
        assign samp = ~fs && ((wsel == 2'h1 && end_p[0]) ||
                              (wsel == 2'h2 && end_p[1]));
        assign clr = fs || wr_mapb || (wsel == 2'h1 && wr_t[0]) ||
                     (wsel == 2'h2 && wr_t[1]);
        assign stat_d[k] = fs || wsel == 2'h0 || wsel == 2'h3;
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                st_q <= CSWT_F_IDLE;
                fcnt_q <= 10'h000;
                cap_q <= 1'b0;
                done_q <= 1'b0;
            end else begin
                done_q <= 1'b0;
                unique case (st_q)
                    CSWT_F_IDLE: if (samp) begin
                        st_q <= CSWT_F_RUN;
                        cap_q <= wake_in_i[k];
                        fcnt_q <= 10'h000;
                    end
                    CSWT_F_RUN: if (fs || wake_in_i[k] != cap_q) begin
                        st_q <= CSWT_F_IDLE;
                    end else if (fcnt_q == 10'(FILT_CYC - 1)) begin
                        st_q <= CSWT_F_IDLE;
                        done_q <= 1'b1;
                    end else begin
                        fcnt_q <= fcnt_q + 10'h001;
                    end
                endcase
            end
        end
        // reference level of the previous cycle
        always_ff @(posedge clk_i) begin
            if (rst_i || clr) begin
                refv_q <= 1'b0;
                ref_q <= 1'b0;
            end else if (done_q) begin
                refv_q <= 1'b1;
                ref_q <= cap_q;
            end
        end
        assign ev_v[k] = done_q & refv_q & (cap_q != ref_q);
        assign smp_v[k] = done_q;
        assign cap_v[k] = cap_q;
    end

    // cyclic wake events skip the first on-time start
    assign cw_ev = start_p & ~first_v & wsrc_q & {2{awake}};

    // configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            map_a_q <= '0;
            map_b_q <= '0;
            wsrc_q <= 2'h0;
        end else begin
            if (wr_mapa) map_a_q <= wdat[2*NHS-1:0];
            if (wr_mapb) map_b_q <= wdat[2*NWK-1:0];
            if (wr_wsrc) wsrc_q <= wdat[1:0];
        end
    end

    // sticky flags, a new event beats a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wk_flag_q <= '0;
            cw_flag_q <= 2'h0;
            cmd_fail_q <= 1'b0;
        end else begin
            wk_flag_q <= (wk_flag_q & ~({NWK{wr_sta}} & wdat[NWK-1:0]))
                         | ev_v;
            cw_flag_q <= (cw_flag_q & ~({2{wr_stb}} & wdat[1:0])) | cw_ev;
            cmd_fail_q <= (cmd_fail_q & ~(wr_ctl & wdat[0])) | (|bad_v);
        end
    end

    // level status follows sampled levels only, in normal and stop mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvl_q <= '0;
        end else begin
            for (int k = 0; k < NWK; k++) begin
                if (smp_v[k] && awake) lvl_q[k] <= cap_v[k];
            end
        end
    end

    // event outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_o <= 1'b0;
            wake_up_o <= 1'b0;
            restart_o <= 1'b0;
            high_side_switch_o <= '0;
            static_sense_o <= '1;
        end else begin
            int_o <= ((|ev_v) && awake) || (|cw_ev);
            wake_up_o <= (|ev_v) && mode_i == CSWT_SLEEP;
            restart_o <= sleep_req_i &&
                         ((|wk_flag_q) || (|cw_flag_q));
            high_side_switch_o <= hs_d;
            static_sense_o <= stat_d;
        end
    end

    // read data
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (adr)
            `CSWT_A_TMR1: rd_d[6:0] = {tset_v[0].on, 1'b0, tset_v[0].per};
            `CSWT_A_TMR2: rd_d[6:0] = {tset_v[1].on, 1'b0, tset_v[1].per};
            `CSWT_A_MAPA: rd_d[2*NHS-1:0] = map_a_q;
            `CSWT_A_MAPB: rd_d[2*NWK-1:0] = map_b_q;
            `CSWT_A_WSRC: rd_d[1:0] = wsrc_q;
            `CSWT_A_STA: rd_d[NWK-1:0] = wk_flag_q;
            `CSWT_A_STB: rd_d[1:0] = cw_flag_q;
            `CSWT_A_LVL: rd_d[NWK-1:0] = lvl_q;
            `CSWT_A_CTL: rd_d[2:0] = {run_v, cmd_fail_q};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // wishbone answer one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= acc;
            if (acc && !wb_req_i.we) wb_dat_o <= rd_d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_tmr_go;
        wr_t[0] && on_ticks(wdat[6:4]) != 8'h00;
    endsequence
    sequence s_change;
        ev_v[0] && mode_i == CSWT_NORMAL;
    endsequence

    a_tmr_go_run: assert property (s_tmr_go |=>
        run_v[0] && first_v[0])
        else $error("timer did not start on write");
    a_cmd_fail_set: assert property (|bad_v |=> cmd_fail_q)
        else $error("command failure not raised");
    a_static_hold: assert property (map_a_q[1:0] == 2'h1 &&
        !run_v[0] && !fault_q[0] && !fs |=> high_side_switch_o[0] ==
        ($past(tset_v[0].on) == `CSWT_ON_OFF_HIGH))
        else $error("static level not held");
    a_map_pulse: assert property (map_a_q[1:0] == 2'h1 && run_v[0] &&
        !fault_q[0] && !fs |=> high_side_switch_o[0] == $past(on_v[0]))
        else $error("mapped switch not following timer");
    a_fault_off: assert property (fault_q[0] |=>
        !high_side_switch_o[0])
        else $error("faulty switch still on");
    a_fault_keep_run: assert property (hs_fault_i[0] && !fs &&
        wr_t == 2'h0 |=> run_v == $past(run_v))
        else $error("fault stopped a timer");
    a_failsafe_off: assert property (fs |=>
        high_side_switch_o == '0 && static_sense_o == '1)
        else $error("fail-safe left cyclic sense active");
    a_sense_int: assert property (s_change |=> int_o && wk_flag_q[0])
        else $error("sense change not signalled");
    a_sense_sleep: assert property (ev_v[0] && mode_i == CSWT_SLEEP
        |=> wake_up_o && !int_o)
        else $error("sleep wake not raised");
    a_filter_drop: assert property (g_wk[0].st_q == CSWT_F_RUN &&
        wake_in_i[0] != g_wk[0].cap_q |=> !smp_v[0] ##1 !ev_v[0])
        else $error("unstable input not filtered");
    a_lvl_sampled: assert property ($changed(lvl_q) |->
        $past(|smp_v))
        else $error("level status changed outside sampling");
    a_first_quiet: assert property (start_p[0] && first_v[0] &&
        !start_p[1] && ev_v == '0 |=> !int_o)
        else $error("first on-time start interrupted");
    a_cyclic_int: assert property (start_p[1] && !first_v[1] &&
        wsrc_q[1] && awake |=> int_o && cw_flag_q[1])
        else $error("cyclic wake interrupt missing");
    a_sleep_restart: assert property (sleep_req_i && |wk_flag_q
        |=> restart_o)
        else $error("pending flag did not restart");
endmodule
`default_nettype wire

// ---- rtl/cswt_consts.svh ----
// constants of the cyclic sense and cyclic wake timer block
`ifndef CSWT_CONSTS_SVH
`define CSWT_CONSTS_SVH
`define CSWT_CLK_NS 25
`define CSWT_TICK_US 100
`define CSWT_TICK_CYC (`CSWT_TICK_US * 1000 / `CSWT_CLK_NS)
`define CSWT_FILT_NS 16000
`define CSWT_FILT_CYC ((`CSWT_FILT_NS + `CSWT_CLK_NS - 1) / `CSWT_CLK_NS)
`define CSWT_PER0_US 10000
`define CSWT_PER1_US 20000
`define CSWT_PER2_US 50000
`define CSWT_PER3_US 100000
`define CSWT_PER4_US 200000
`define CSWT_PER5_US 1000000
`define CSWT_PER6_US 2000000
`define CSWT_ON1_US 100
`define CSWT_ON2_US 300
`define CSWT_ON3_US 1000
`define CSWT_ON4_US 10000
`define CSWT_ON5_US 20000
`define CSWT_ON_OFF_LOW 3'h0
`define CSWT_ON_OFF_HIGH 3'h6
`define CSWT_ON_LSB 4
`define CSWT_PER_LSB 0
`define CSWT_A_TMR1 8'h00
`define CSWT_A_TMR2 8'h04
`define CSWT_A_MAPA 8'h08
`define CSWT_A_MAPB 8'h0C
`define CSWT_A_WSRC 8'h10
`define CSWT_A_STA 8'h14
`define CSWT_A_STB 8'h18
`define CSWT_A_LVL 8'h1C
`define CSWT_A_CTL 8'h20
`define CSWT_RST_ON 3'h0
`define CSWT_RST_PER 3'h0
`endif

// ---- rtl/cswt_pkg.sv ----
// types of the cyclic sense and cyclic wake timer block
`default_nettype none
package cswt_pkg;
    typedef enum logic [1:0] {
        CSWT_NORMAL = 2'h0,
        CSWT_STOP = 2'h1,
        CSWT_SLEEP = 2'h3,
        CSWT_FAILSAFE = 2'h2
    } cswt_mode_e;
    typedef enum logic {CSWT_F_IDLE = 1'h0, CSWT_F_RUN = 1'h1} cswt_filt_e;
    typedef struct packed {
        logic [2:0] on;
        logic [2:0] per;
    } cswt_tset_s;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } cswt_wb_req_s;
endpackage
`default_nettype wire

// ---- dv/cswt_wk_array.sv ----
// behavioural switch array seen on the three wake inputs
`default_nettype none
module cswt_wk_array (
    input wire logic clk_i,
    input wire logic [2:0] contact_i,
    input wire logic chatter_i,
    output logic [2:0] wake_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip_q = 1'b0;
    // chatter flips the lines every cycle so no filter can settle
    always @(posedge clk_i) begin
        flip_q <= chatter_i ? ~flip_q : 1'b0;
    end
    // contacts tied to a fixed rail, chatter laid on top
    assign wake_o = contact_i ^ {3{flip_q}};
endmodule
`default_nettype wire

// ---- dv/tb_cswt_top.sv ----
// self-checking bench of the cyclic sense and cyclic wake timers
`include "cswt_consts.svh"
`default_nettype none
module tb_cswt_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cswt_pkg::*;
    localparam int TK = 40;
    localparam int PER0 = 100 * TK;
    int ontk[3] = '{1, 3, 10};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    cswt_wb_req_s req = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    cswt_mode_e mode = CSWT_NORMAL;
    logic slp = 1'b0;
    logic [2:0] contact = 3'h0;
    logic chat = 1'b0;
    logic [2:0] wk;
    logic [3:0] flt = 4'h0;
    logic [3:0] hs;
    logic [2:0] ss;
    logic int_o;
    logic wake_up_o;
    logic restart_o;
    logic [31:0] rd;
    int err_total = 0;
    int tests_run = 0;
    int n_int = 0;
    int n_wk = 0;
    int n_rs = 0;
    int n_hs = 0;
    int cyc_n = 0;
    int w;
    int g;
    int k;
    int j;

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;

    cswt_top #(.TICK_CYC(TK)) uut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_req_i(req),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .mode_i(mode),
        .sleep_req_i(slp),
        .wake_in_i(wk),
        .hs_fault_i(flt),
        .high_side_switch_o(hs),
        .static_sense_o(ss),
        .int_o(int_o),
        .wake_up_o(wake_up_o),
        .restart_o(restart_o)
    );

    cswt_wk_array far (
        .clk_i(clk_i),
        .contact_i(contact),
        .chatter_i(chat),
        .wake_o(wk)
    );

    // pulse counters and the cycle ceiling
    always @(posedge clk_i) begin
        if (int_o === 1'b1) n_int++;
        if (wake_up_o === 1'b1) n_wk++;
        if (restart_o === 1'b1) n_rs++;
        if (hs[0] === 1'b1) n_hs++;
        cyc_n++;
        if (cyc_n == 90000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one classic wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        req <= '0;
        if (n >= 50) chk("wb_ack", 32'h0, 32'h1);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                        input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // width and gap of the next pulse on switch 0
    task automatic meas();
        int n;
        n = 0;
        w = 0;
        g = 0;
        while (hs[0] === 1'b1 && n < 9000) begin
            @(posedge clk_i);
            n++;
        end
        while (hs[0] !== 1'b1 && n < 18000) begin
            @(posedge clk_i);
            n++;
        end
        while (hs[0] === 1'b1 && w < 9000) begin
            @(posedge clk_i);
            w++;
        end
        while (hs[0] !== 1'b1 && g < 9000) begin
            @(posedge clk_i);
            g++;
        end
    endtask

    task automatic sleep_pulse();
        slp <= 1'b1;
        @(posedge clk_i);
        slp <= 1'b0;
        cyc(3);
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("static_rst", 32'(ss), 32'h7);
        chk("hs_rst", 32'(hs), 32'h0);
        for (int i = 0; i < 10; i++) begin
            rchk(8'(i * 4), 32'h0, "reg_rst");
        end
        wb(1'b1, 8'h24, 32'hFFFF_FFFF);
        rchk(8'h24, 32'h0, "unmapped");
        // static levels before any sensing starts
        wb(1'b1, `CSWT_A_MAPA, 32'h9);
        rchk(`CSWT_A_MAPA, 32'h9, "map_a");
        wb(1'b1, `CSWT_A_TMR1, 32'h60);
        wb(1'b1, `CSWT_A_TMR2, 32'h60);
        cyc(3);
        chk("hs_high", 32'(hs), 32'h3);
        wb(1'b1, `CSWT_A_TMR1, 32'h0);
        wb(1'b1, `CSWT_A_TMR2, 32'h0);
        cyc(3);
        chk("hs_low", 32'(hs), 32'h0);
        // on-time above the period is taken but flagged
        wb(1'b1, `CSWT_A_TMR1, 32'h50);
        rchk(`CSWT_A_CTL, 32'h3, "ctl_fail");
        wb(1'b1, `CSWT_A_CTL, 32'h1);
        wb(1'b1, `CSWT_A_TMR1, 32'h10);
        rchk(`CSWT_A_CTL, 32'h2, "ctl_run");
        // 20 ms on-time against every longer or equal period
        for (int i = 1; i <= 6; i++) begin
            wb(1'b1, `CSWT_A_TMR1, 32'h50 | 32'(i));
            rchk(`CSWT_A_CTL, 32'h2, "on_eq_per");
        end
        // pulse width per on-time code
        for (int i = 1; i <= 3; i++) begin
            wb(1'b1, `CSWT_A_TMR1, 32'(i << 4));
            meas();
            chk("on_width", 32'(w), 32'(ontk[i - 1] * TK));
            chk("period", 32'(w + g), 32'(PER0));
        end
        wb(1'b1, `CSWT_A_TMR1, 32'h41);
        meas();
        chk("on_width_b", 32'(w), 32'(100 * TK));
        chk("period_b", 32'(w + g), 32'(2 * PER0));
        // a switch fault turns the switch off, timer keeps going
        flt <= 4'h1;
        cyc(3);
        k = n_hs;
        cyc(5000);
        chk("fault_off", 32'(n_hs - k), 32'h0);
        rchk(`CSWT_A_CTL, 32'h2, "fault_run");
        flt <= 4'h0;
        wb(1'b1, `CSWT_A_MAPA, 32'h9);
        // cyclic sense on wake input 1
        wb(1'b1, `CSWT_A_TMR1, 32'h0);
        wb(1'b1, `CSWT_A_MAPB, 32'h1);
        cyc(2);
        chk("static_map", 32'(ss), 32'h6);
        wb(1'b1, `CSWT_A_TMR1, 32'h10);
        cyc(2000);
        contact <= 3'h1;
        k = n_int;
        rchk(`CSWT_A_LVL, 32'h0, "lvl_held");
        cyc(4500);
        chk("int_normal", 32'(n_int - k), 32'h1);
        rchk(`CSWT_A_STA, 32'h1, "flag_in1");
        rchk(`CSWT_A_LVL, 32'h1, "lvl_sampled");
        mode <= CSWT_STOP;
        wb(1'b1, `CSWT_A_STA, 32'h1);
        contact <= 3'h0;
        k = n_int;
        cyc(4500);
        chk("int_stop", 32'(n_int - k), 32'h1);
        mode <= CSWT_SLEEP;
        contact <= 3'h1;
        k = n_int;
        j = n_wk;
        cyc(4500);
        chk("wake_sleep", 32'(n_wk - j), 32'h1);
        chk("int_sleep", 32'(n_int - k), 32'h0);
        // chatter never settles the filter, then returns to the reference
        chat <= 1'b1;
        j = n_wk;
        cyc(4500);
        chat <= 1'b0;
        cyc(4500);
        chk("chatter", 32'(n_wk - j), 32'h0);
        // sleep request with and without a pending flag
        k = n_rs;
        sleep_pulse();
        chk("restart", 32'(n_rs - k), 32'h1);
        rchk(`CSWT_A_STA, 32'h1, "flag_kept");
        wb(1'b1, `CSWT_A_STA, 32'h7);
        wb(1'b1, `CSWT_A_STB, 32'h3);
        k = n_rs;
        sleep_pulse();
        chk("no_restart", 32'(n_rs - k), 32'h0);
        // cyclic wake on timer 2
        mode <= CSWT_NORMAL;
        wb(1'b1, `CSWT_A_TMR1, 32'h0);
        wb(1'b1, `CSWT_A_TMR2, 32'h0);
        wb(1'b1, `CSWT_A_WSRC, 32'h2);
        wb(1'b1, `CSWT_A_TMR2, 32'h10);
        k = n_int;
        cyc(10000);
        chk("wake_ints", 32'(n_int - k), 32'h2);
        rchk(`CSWT_A_STB, 32'h2, "flag_tmr2");
        // fail-safe drops switches and restores static sensing
        wb(1'b1, `CSWT_A_TMR1, 32'h60);
        cyc(3);
        chk("hs_pre_fs", 32'(hs[0]), 32'h1);
        mode <= CSWT_FAILSAFE;
        cyc(3);
        chk("fs_hs", 32'(hs), 32'h0);
        chk("fs_static", 32'(ss), 32'h7);
        end_of_test();
    end
endmodule
`default_nettype wire
